// ### core/nsoc_div.v
// Purpose: sequential restoring divider, 40-bit by 26-bit
// Assumes: go only while not busy; divisor never zero
// Notes: done pulses 40 cycles after go
`timescale 1ns/100ps
`default_nettype none
module nsoc_div (
  // clock and reset
  input wire mclk,
  input wire rst,
  // request
  input wire go,
  input wire [39:0] num,
  input wire [25:0] den,
  // answer
  output reg busy,
  output reg done,
  output reg [39:0] quo
);
  reg [26:0] rem_q;
  reg [5:0] cnt_q;
  wire [26:0] rem_s = {rem_q[25:0], quo[39]};
  wire ge = rem_s >= {1'b0, den};

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      rem_q <= 27'h0000000;
      cnt_q <= 6'h00;
      busy <= 1'b0;
      done <= 1'b0;
      quo <= 40'h0000000000;
    end else begin
      done <= 1'b0;
      if (go && !busy) begin
        rem_q <= 27'h0000000;
        quo <= num;
        cnt_q <= 6'h28;
        busy <= 1'b1;
      end else if (busy) begin
        rem_q <= ge ? rem_s - {1'b0, den} : rem_s;
        quo <= {quo[38:0], ge};
        cnt_q <= cnt_q - 6'h01;
        if (cnt_q == 6'h01) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end
endmodule // nsoc_div
`default_nettype wire

// ### core/nsoc_tick.v
// Purpose: one-cycle enable every 0.1 ms
// Assumes: mclk at the rate in the constants header
// Notes: free running from reset
`timescale 1ns/100ps
`default_nettype none
`include "nsoc_regs.vh"
module nsoc_tick #(parameter TICK_CYC = `NSOC_TICK_CYC) (
  // clock and reset
  input wire mclk,
  input wire rst,
  // enable out
  output reg tick
);
  localparam integer LAST_I = TICK_CYC - 1;
  localparam [9:0] LAST = LAST_I[9:0];
  reg [9:0] cnt_q;

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_q <= 10'h000;
      tick <= 1'b0;
    end else begin
      tick <= (cnt_q == LAST);
      if (cnt_q == LAST)
        cnt_q <= 10'h000;
      else
        cnt_q <= cnt_q + 10'h001;
    end
  end
endmodule // nsoc_tick
`default_nettype wire

// ### core/nsoc_top.v
// Purpose: negative sequence overcurrent element with APB settings
// Assumes: meas_current is percent of nominal with 4 fraction bits
// Notes: delays are integrated in 0.1 ms ticks; the multiplier scales inverse operate and ANSI reset targets
//
// Design decisions made here: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "nsoc_regs.vh"
module nsoc_top #(parameter TICK_CYC = `NSOC_TICK_CYC) (
  // clock and reset
  input wire mclk,
  input wire rst,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // negative sequence current magnitude
  input wire [15:0] meas_current,
  // protection outputs
  output reg start_output,
  output reg trip_output,
  output wire irq
);
  localparam [1:0] SQ_IDLE = 2'h0;
  localparam [1:0] SQ_RAT = 2'h1;
  localparam [1:0] SQ_TIM = 2'h2;
  localparam [1:0] AL_LOG = 2'h0;
  localparam [1:0] AL_LIN = 2'h1;
  localparam [1:0] AL_SQR = 2'h2;

  // settings
  reg [3:0] sel_q;
  reg [9:0] start_q;
  reg [10:0] tms_q;
  reg [15:0] mindel_q;
  reg [15:0] defdel_q;
  reg [15:0] rstdel_q;
  reg [1:0] ista_q;
  reg [1:0] imask_q;

  // curve constants {alpha, c, kr, k}, times in 0.1 ms
  function [54:0] curve;
    input [3:0] s;
    begin
      case (s)
        4'h2: curve = {AL_LOG, 13'h0000, 19'h00000, 21'h000578};
        4'h3: curve = {AL_LIN, 13'h0000, 19'h00000, 21'h020F58};
        4'h4: curve = {AL_SQR, 13'h0000, 19'h00000, 21'h0C3500};
        4'h5: curve = {AL_LIN, 13'h0000, 19'h00000, 21'h124F80};
        4'h6: curve = {AL_LOG, 13'h00B9, 19'h011F8, 21'h000056};
        4'h7: curve = {AL_LOG, 13'h0474, 19'h0BD74, 21'h000203};
        4'h8: curve = {AL_SQR, 13'h132E, 19'h34BC0, 21'h02FE04};
        4'h9: curve = {AL_SQR, 13'h04C1, 19'h470B8, 21'h044D90};
        4'hA: curve = {AL_LOG, 13'h073A, 19'h0B3B0, 21'h00035C};
        4'hB: curve = {AL_SQR, 13'h1BD0, 19'h20DC8, 21'h045B3C};
        4'hC: curve = {AL_SQR, 13'h09C4, 19'h493E0, 21'h09C6BC};
        default: curve = 55'h0;
      endcase
    end
  endfunction

  function [15:0] clamp16;
    input [31:0] v;
    input [15:0] lo;
    input [15:0] hi;
    begin
      if (v < {16'h0000, lo})
        clamp16 = lo;
      else if (v > {16'h0000, hi})
        clamp16 = hi;
      else
        clamp16 = v[15:0];
    end
  endfunction

  // log2 of a Q8 ratio above one, Q16
  function [31:0] log2q;
    input [12:0] r;
    integer i;
    reg [3:0] p;
    reg [28:0] fr;
    begin
      p = 4'h8;
      for (i = 9; i < 13; i = i + 1)
        if (r[i])
          p = i[3:0];
      fr = {r - (13'h0001 << p), 16'h0000} >> p;
      log2q = {12'h000, p - 4'h8, 16'h0000} + {3'h0, fr};
    end
  endfunction

  // apb slave, zero wait states
  wire setup = psel && !penable;
  wire acc_ph = psel && penable;
  reg map_hit;
  reg [31:0] rd_d;
  assign pready = 1'b1;
  assign pslverr = acc_ph && !map_hit;

  always @* begin
    map_hit = 1'b1;
    rd_d = 32'h00000000;
    case (paddr)
      `NSOC_A_CTRL: rd_d = {28'h0000000, sel_q};
      `NSOC_A_START: rd_d = {22'h000000, start_q};
      `NSOC_A_TMS: rd_d = {21'h000000, tms_q};
      `NSOC_A_MINDEL: rd_d = {16'h0000, mindel_q};
      `NSOC_A_DEFDEL: rd_d = {16'h0000, defdel_q};
      `NSOC_A_RSTDEL: rd_d = {16'h0000, rstdel_q};
      `NSOC_A_STATUS: rd_d = {30'h00000000, trip_output, start_output};
      `NSOC_A_ISTAT: rd_d = {30'h00000000, ista_q};
      `NSOC_A_IMASK: rd_d = {30'h00000000, imask_q};
      default: map_hit = 1'b0;
    endcase
  end

  always @(posedge mclk or posedge rst) begin
    if (rst)
      prdata <= 32'h00000000;
    else if (setup && !pwrite)
      prdata <= rd_d;
  end

  wire [15:0] start_cl = clamp16(pwdata, {6'h00, `NSOC_START_MIN},
    {6'h00, `NSOC_START_MAX});
  wire [15:0] tms_cl = clamp16(pwdata, {5'h00, `NSOC_TMS_MIN},
    {5'h00, `NSOC_TMS_MAX});
  wire wr = acc_ph && pwrite;
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      sel_q <= `NSOC_RST_SEL;
      start_q <= `NSOC_RST_START;
      tms_q <= `NSOC_RST_TMS;
      mindel_q <= `NSOC_RST_DELAY;
      defdel_q <= `NSOC_RST_DELAY;
      rstdel_q <= `NSOC_RST_DELAY;
      imask_q <= 2'h0;
    end else if (wr) begin
      case (paddr)
        `NSOC_A_CTRL:
          if (pwdata[3:0] <= `NSOC_SEL_MAX)
            sel_q <= pwdata[3:0];
        `NSOC_A_START:
          start_q <= start_cl[9:0];
        `NSOC_A_TMS:
          tms_q <= tms_cl[10:0];
        `NSOC_A_MINDEL:
          mindel_q <= clamp16(pwdata, `NSOC_DEL_MIN, `NSOC_DEL_MAX);
        `NSOC_A_DEFDEL:
          defdel_q <= clamp16(pwdata, `NSOC_DEL_MIN, `NSOC_DEL_MAX);
        `NSOC_A_RSTDEL:
          rstdel_q <= clamp16(pwdata, `NSOC_RDEL_MIN, `NSOC_DEL_MAX);
        `NSOC_A_IMASK: imask_q <= pwdata[1:0];
        default: imask_q <= imask_q;
      endcase
    end
  end

  // operate condition
  wire on = sel_q != `NSOC_SEL_OFF;
  wire is_def = sel_q == `NSOC_SEL_DEF;
  wire is_iec = !is_def && on && sel_q <= `NSOC_SEL_IEC_HI;
  wire above = on && (meas_current > {2'h0, start_q, 4'h0});
  wire [54:0] cv = curve(sel_q);
  wire [1:0] alpha = cv[54:53];

  // delay computation sequencer
  reg [1:0] sq_q;
  reg op_q;
  reg rs_val_q;
  reg [43:0] op_prod_q;
  reg [43:0] rs_prod_q;
  reg div_go;
  reg [39:0] div_num;
  reg [25:0] div_den;
  wire div_busy;
  wire div_done;
  wire [39:0] div_quo;

  nsoc_div u_div (
    .mclk(mclk),
    .rst(rst),
    .go(div_go),
    .num(div_num),
    .den(div_den),
    .busy(div_busy),
    .done(div_done),
    .quo(div_quo)
  );

  // ratio clamped at twenty times start
  wire [12:0] rat_c = (div_quo > {27'h0, `NSOC_RAT_MAX}) ?
    `NSOC_RAT_MAX : div_quo[12:0];
  wire [25:0] sq = {13'h0000, rat_c} * {13'h0000, rat_c};
  wire [31:0] lg = log2q(rat_c) * `NSOC_LN2_A;
  reg [25:0] f_d;
  always @* begin
    case (alpha)
      AL_LIN: f_d = {5'h00, rat_c - `NSOC_RAT_ONE, 8'h00};
      AL_SQR: f_d = sq - `NSOC_Q16_ONE;
      default: f_d = {10'h000, lg[31:16]};
    endcase
    if (!op_q)
      f_d = `NSOC_Q16_ONE - sq;
    if (f_d == 26'h0000000 || rat_c <= `NSOC_RAT_ONE && op_q)
      f_d = 26'h0000001;
  end

  wire [39:0] q_raw = div_quo + (op_q ? {27'h0, cv[52:40]} : 40'h0);
  wire [31:0] q_sat = (q_raw[39:32] != 8'h00) ? 32'hFFFFFFFF : q_raw[31:0];
  wire [43:0] prod = {12'h000, q_sat} * {33'h0, tms_q};

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      sq_q <= SQ_IDLE;
      op_q <= 1'b0;
      rs_val_q <= 1'b0;
      op_prod_q <= 44'h0;
      rs_prod_q <= 44'h0;
      div_go <= 1'b0;
      div_num <= 40'h0;
      div_den <= 26'h0000001;
    end else begin
      div_go <= 1'b0;
      case (sq_q)
        SQ_IDLE:
          if (on && !is_def && !div_busy && !div_go) begin
            op_q <= above;
            div_num <= {20'h00000, meas_current, 4'h0};
            div_den <= {16'h0000, start_q};
            div_go <= 1'b1;
            sq_q <= SQ_RAT;
          end
        SQ_RAT:
          if (div_done) begin
            if (op_q || !is_iec) begin
              div_num <= op_q ? {3'h0, cv[20:0], 16'h0000}
                              : {5'h00, cv[39:21], 16'h0000};
              div_den <= f_d;
              div_go <= 1'b1;
              sq_q <= SQ_TIM;
            end else
              sq_q <= SQ_IDLE;
          end
        SQ_TIM:
          if (div_done) begin
            if (op_q) begin
              op_prod_q <= prod;
            end else begin
              rs_prod_q <= prod;
              rs_val_q <= 1'b1;
            end
            sq_q <= SQ_IDLE;
          end
        default: sq_q <= SQ_IDLE;
      endcase
      if (above)
        rs_val_q <= 1'b0;
    end
  end

  // targets in units of ticks times 100
  wire [43:0] min_tgt = {28'h0, mindel_q} * `NSOC_MS_SCALE;
  wire [43:0] def_tgt = {28'h0, defdel_q} * `NSOC_MS_SCALE;
  wire [43:0] inv_tgt = (op_prod_q < min_tgt) ? min_tgt : op_prod_q;
  wire [43:0] op_tgt = is_def ? def_tgt : inv_tgt;
  wire [43:0] rs_tgt = is_iec ? {28'h0, rstdel_q} * `NSOC_MS_SCALE
                              : rs_prod_q;

  // operate and reset integration
  wire tick;
  reg [43:0] acc_q;
  reg [43:0] racc_q;

  nsoc_tick #(.TICK_CYC(TICK_CYC)) u_tick (
    .mclk(mclk),
    .rst(rst),
    .tick(tick)
  );

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      acc_q <= 44'h0;
      racc_q <= 44'h0;
      start_output <= 1'b0;
      trip_output <= 1'b0;
    end else if (!on) begin
      acc_q <= 44'h0;
      racc_q <= 44'h0;
      start_output <= 1'b0;
      trip_output <= 1'b0;
    end else begin
      start_output <= above;
      if (above) begin
        racc_q <= 44'h0;
        if (!trip_output && acc_q >= op_tgt)
          trip_output <= 1'b1;
        else if (tick && !trip_output)
          acc_q <= acc_q + `NSOC_ACC_STEP;
      end else if (is_def) begin
        acc_q <= 44'h0;
        trip_output <= 1'b0;
      end else if (acc_q != 44'h0 || trip_output) begin
        if ((is_iec || rs_val_q) && racc_q >= rs_tgt) begin
          acc_q <= 44'h0;
          racc_q <= 44'h0;
          trip_output <= 1'b0;
        end else if (tick)
          racc_q <= racc_q + `NSOC_ACC_STEP;
      end
    end
  end

  // sticky events, cleared by reading, set wins
  reg start_d1_q;
  reg trip_d1_q;
  wire [1:0] ev = {trip_output && !trip_d1_q, start_output && !start_d1_q};
  wire rd_ist = acc_ph && !pwrite && paddr == `NSOC_A_ISTAT;
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      start_d1_q <= 1'b0;
      trip_d1_q <= 1'b0;
      ista_q <= 2'h0;
    end else begin
      start_d1_q <= start_output;
      trip_d1_q <= trip_output;
      ista_q <= (ista_q & ~(rd_ist ? prdata[1:0] : 2'h0)) | ev;
    end
  end
  assign irq = |(ista_q & imask_q);
endmodule // nsoc_top
`default_nettype wire

// ### include/nsoc_regs.vh
// Purpose: constants of the negative sequence overcurrent element
// Assumes: 10 MHz mclk, APB register access, 32-bit words
// Notes: times count in 0.1 ms ticks; ratios are unsigned Q8
//
// Overview of operation
// - start is raised only while measured current exceeds the start setting
// - one input: RMS fundamental of negative sequence current from upstream
// - definite mode trips after the definite delay, whatever the magnitude
// - inverse mode delay is TMS times k over ratio^alpha minus one, plus c
// - above twenty times start the ratio is clamped, giving a fixed delay
// - inverse curve holds from 1.1 times start and always reaches trip there
// - ANSI curves reset after TMS times kr over one minus ratio squared
// - IEC curves reset after the fixed reset delay setting
// - inverse trip never comes sooner than the minimum delay setting
// - time multiplier scales operate delays of inverse curves and reset delays of ANSI curves
// - selection is off, definite, or one of eleven curves; off by default
// - start setting spans 10 to 1000 percent, step 1, default 50
// - minimum and definite delay 40..60000 ms default 100; reset 60..60000
// - two binary outputs: start indication and trip command
`ifndef NSOC_REGS_VH
`define NSOC_REGS_VH

`define NSOC_A_CTRL 12'h000
`define NSOC_A_START 12'h004
`define NSOC_A_TMS 12'h008
`define NSOC_A_MINDEL 12'h00C
`define NSOC_A_DEFDEL 12'h010
`define NSOC_A_RSTDEL 12'h014
`define NSOC_A_STATUS 12'h018
`define NSOC_A_ISTAT 12'h01C
`define NSOC_A_IMASK 12'h020

`define NSOC_B_START 0
`define NSOC_B_TRIP 1

`define NSOC_SEL_OFF 4'h0
`define NSOC_SEL_DEF 4'h1
`define NSOC_SEL_IEC_HI 4'h5
`define NSOC_SEL_MAX 4'hC

`define NSOC_RST_SEL 4'h0
`define NSOC_RST_START 10'h032
`define NSOC_RST_TMS 11'h064
`define NSOC_RST_DELAY 16'h0064

`define NSOC_START_MIN 10'h00A
`define NSOC_START_MAX 10'h3E8
`define NSOC_TMS_MIN 11'h005
`define NSOC_TMS_MAX 11'h5DC
`define NSOC_DEL_MIN 16'h0028
`define NSOC_RDEL_MIN 16'h003C
`define NSOC_DEL_MAX 16'hEA60

`define NSOC_CLK_HZ 10000000
`define NSOC_TICK_NS 100000
`define NSOC_TICK_CYC ((`NSOC_CLK_HZ / 1000) * `NSOC_TICK_NS / 1000000)
`define NSOC_ACC_STEP 44'h00000000064
`define NSOC_MS_SCALE 44'h000000003E8

`define NSOC_RAT_ONE 13'h0100
`define NSOC_RAT_MAX 13'h1400
`define NSOC_Q16_ONE 26'h0010000
`define NSOC_LN2_A 32'h0000038C

`endif

// ### tb/nsoc_chk_sva.sv
// Purpose: port checker of the overcurrent element
// Assumes: settings mirrored from apb writes
// Notes: bound to nsoc_top
`timescale 1ns/100ps
`default_nettype none
`include "nsoc_regs.vh"
module nsoc_chk #(parameter int TICK_CYC = `NSOC_TICK_CYC) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // protection
  input wire logic [15:0] meas_current,
  input wire logic start_output,
  input wire logic trip_output,
  input wire logic irq
);
  logic [3:0] sel_q;
  logic [9:0] st_q;
  logic [31:0] run_q;
  logic [15:0] dd_q;
  wire [31:0] def_min = ({16'h0, dd_q} * 32'd10 - 32'd1) * TICK_CYC;
  wire wr = psel && penable && pwrite;
  wire bad = paddr > `NSOC_A_IMASK || paddr[1:0] != 2'h0;
  wire above = sel_q != 4'h0 && meas_current > {2'h0, st_q, 4'h0};
  // mirror of curve and start settings, run length of start
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sel_q <= `NSOC_RST_SEL;
      st_q <= `NSOC_RST_START;
      run_q <= 32'h0;
      dd_q <= `NSOC_RST_DELAY;
    end else begin
      if (wr && paddr == `NSOC_A_CTRL && pwdata[3:0] <= 4'hC)
        sel_q <= pwdata[3:0];
      if (wr && paddr == `NSOC_A_START)
        st_q <= pwdata < 32'hA ? 10'h00A :
          pwdata > 32'h3E8 ? 10'h3E8 : pwdata[9:0];
      if (wr && paddr == `NSOC_A_DEFDEL)
        dd_q <= pwdata < 32'h28 ? 16'h0028 :
          pwdata > 32'hEA60 ? 16'hEA60 : pwdata[15:0];
      run_q <= !start_output ? 32'h0 :
        run_q + {31'h0, run_q != 32'hFFFFFFFF};
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_access;
    psel && !penable ##1 psel && penable;
  endsequence
  a_start_follows: assert property (start_output == $past(above))
    else $error("start output does not follow pickup");
  a_off_quiet: assert property (sel_q == 4'h0 |=> !start_output && !trip_output)
    else $error("output active while off");
  a_def_time: assert property ($rose(trip_output) && sel_q == 4'h1 |-> run_q >= def_min)
    else $error("definite trip too early");
  a_def_drop: assert property (sel_q == 4'h1 && !above |=> !trip_output)
    else $error("definite trip not dropped");
  a_trip_holds: assert property (sel_q == 4'h1 && above && trip_output |=> trip_output)
    else $error("trip lost while operating");
  a_zero_wait: assert property (s_access |-> pready)
    else $error("access not answered");
  a_slverr_map: assert property (s_access |-> pslverr == bad)
    else $error("error response wrong");
  a_bad_read: assert property (s_access ##0 (!pwrite && bad) |-> prdata == 32'h0)
    else $error("unmapped read not zero");
endmodule // nsoc_chk
bind nsoc_top nsoc_chk #(.TICK_CYC(TICK_CYC)) i_chk (.mclk(mclk),
  .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .meas_current(meas_current), .start_output(start_output),
  .trip_output(trip_output), .irq(irq));
`default_nettype wire

// ### tb/nsoc_meas_src.sv
// Purpose: upstream preparation model feeding the current magnitude
// Assumes: level is commanded by the bench
// Notes: output is registered, one value per clock
`timescale 1ns/100ps
`default_nettype none
module nsoc_meas_src (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // commanded level and output
  input wire logic [15:0] lvl,
  output var logic [15:0] meas_current
);
  // single quantity: rms fundamental of negative sequence current
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      meas_current <= 16'h0000;
    end else begin
      meas_current <= lvl;
    end
  end
endmodule // nsoc_meas_src
`default_nettype wire

// ### tb/nsoc_top_tb.sv
// Purpose: register, definite and inverse timing tests of the overcurrent element
// Assumes: 10 MHz mclk, zero wait apb
// Notes: tick shortened to 10 clocks, so 1 ms takes 100 clocks
`timescale 1ns/100ps
`default_nettype none
`include "nsoc_regs.vh"
module nsoc_top_tb;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rv;
  logic pready, pslverr, ev, start_output, trip_output, irq;
  logic [15:0] lvl = 16'h0000, meas_current;
  int failures = 0, tests_run = 0, cyc = 0, n;
  always #50 mclk = ~mclk;
  nsoc_meas_src i_src (.mclk(mclk), .rst(rst), .lvl(lvl),
    .meas_current(meas_current));
  nsoc_top #(.TICK_CYC(10)) i_dut (.mclk(mclk), .rst(rst), .psel(psel),
    .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .meas_current(meas_current),
    .start_output(start_output), .trip_output(trip_output), .irq(irq));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rv, exp);
  endtask
  task automatic lv(input logic [15:0] v);
    @(posedge mclk);
    lvl <= v;
    repeat (4) @(posedge mclk);
  endtask
  task automatic wt(input logic v);
    n = 0;
    while (trip_output !== v && n < 8000) begin
      n++;
      @(posedge mclk);
    end
  endtask
  task automatic complete_run;
    if (failures == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      failures++;
      complete_run();
    end
  end
  initial begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    rd(`NSOC_A_CTRL, 32'h0);
    rd(`NSOC_A_START, 32'h32);
    rd(`NSOC_A_MINDEL, 32'h64);
    rd(`NSOC_A_DEFDEL, 32'h64);
    rd(`NSOC_A_RSTDEL, 32'h64);
    rd(12'h040, 32'h0);
    chk(ev, 1'b1);
    apb(1'b1, `NSOC_A_START, 32'h5);
    rd(`NSOC_A_START, 32'hA);
    apb(1'b1, `NSOC_A_START, 32'h3E9);
    rd(`NSOC_A_START, 32'h3E8);
    apb(1'b1, `NSOC_A_CTRL, 32'hD);
    rd(`NSOC_A_CTRL, 32'h0);
    lv(16'hFFFF);
    chk(start_output, 1'b0);
    lv(16'h0000);
    apb(1'b1, `NSOC_A_START, 32'h32);
    apb(1'b1, `NSOC_A_DEFDEL, 32'h28);
    apb(1'b1, `NSOC_A_IMASK, 32'h3);
    apb(1'b1, `NSOC_A_CTRL, `NSOC_SEL_DEF);
    lv(16'h0320);
    chk(start_output, 1'b0);
    lv(16'h0321);
    chk(start_output, 1'b1);
    chk(irq, 1'b1);
    rd(`NSOC_A_ISTAT, 32'h1);
    wt(1'b1);
    chk(n > 3980 && n < 4010, 1'b1);
    rd(`NSOC_A_STATUS, 32'h3);
    chk(irq, 1'b1);
    rd(`NSOC_A_ISTAT, 32'h2);
    lv(16'h0000);
    chk({start_output, trip_output}, 2'h0);
    lv(16'h0321);
    chk(start_output, 1'b1);
    apb(1'b1, `NSOC_A_CTRL, `NSOC_SEL_OFF);
    repeat (2) @(posedge mclk);
    chk({start_output, trip_output}, 2'h0);
    lv(16'h0000);
    rd(`NSOC_A_TMS, 32'h64);
    apb(1'b1, `NSOC_A_TMS, 32'hA);
    apb(1'b1, `NSOC_A_MINDEL, 32'h28);
    apb(1'b1, `NSOC_A_RSTDEL, 32'h3C);
    apb(1'b1, `NSOC_A_CTRL, 32'h3);
    lv(16'h7D00);
    chk(start_output, 1'b1);
    wt(1'b1);
    chk(n > 7000 && n < 7200, 1'b1);
    lv(16'h0000);
    chk({start_output, trip_output}, 2'h1);
    wt(1'b0);
    chk(n > 5900 && n < 6100, 1'b1);
    apb(1'b1, `NSOC_A_TMS, 32'h5);
    lv(16'h7D00);
    wt(1'b1);
    chk(n > 3950 && n < 4050, 1'b1);
    apb(1'b1, `NSOC_A_CTRL, `NSOC_SEL_OFF);
    repeat (2) @(posedge mclk);
    chk({start_output, trip_output}, 2'h0);
    complete_run();
  end
endmodule // nsoc_top_tb
`default_nettype wire
